// ---- design/sta_ahb_slave.sv ----
// AHB-Lite slave front end: zero-wait writes, one-wait registered reads
// assumes it is the only slave, so hready equals its own hreadyout
`timescale 1ns/1ps
`include "sta_regs.svh"

module sta_ahb_slave (
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // register side
    output logic [`STA_OFF_W-1:0]      reg_addr,
    output logic                       wr_en,
    output logic                       rd_en,
    input  wire logic [31:0]           rd_data
);

    logic                  phase_q;
    logic                  write_q;
    logic                  done_q;
    logic [`STA_OFF_W-1:0] addr_q;
    logic [31:0]           hrdata_q;

    // ------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= 1'b0;
            write_q <= 1'b0;
            addr_q  <= '0;
            done_q  <= 1'b0;
        end else if (hready) begin
            phase_q <= hsel & htrans[`STA_HTRANS_ACTIVE];
            write_q <= hwrite;
            addr_q  <= haddr[`STA_OFF_W-1:0];
            done_q  <= 1'b0;
        end else begin
            done_q  <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read data register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (rd_en) begin
            hrdata_q <= rd_data;
        end
    end

    assign rd_en     = phase_q & ~write_q & ~done_q;
    assign wr_en     = phase_q & write_q;
    assign reg_addr  = addr_q;
    assign hreadyout = ~rd_en;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_en |=> hreadyout && !rd_en)
        else $error("read did not complete one cycle after its wait state");

endmodule

// ---- design/sta_line_wait.sv ----
// line-start wait timer for the framing logic
// assumes line_start is a one-cycle pulse at the start of each line
`timescale 1ns/1ps
`include "sta_regs.svh"

module sta_line_wait #(
    parameter int WAIT_W = `STA_W_WAIT
) (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // control
    input  wire logic              line_start,
    input  wire logic [WAIT_W-1:0] wait_cnt,
    // status
    output logic                   line_go,
    output logic                   waiting
);

    sta_pkg::sta_lw_state_e state_q;
    logic [WAIT_W-1:0]      count_q;
    logic [WAIT_W-1:0]      elapsed_q;
    logic [WAIT_W-1:0]      loaded_q;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= sta_pkg::STA_LW_IDLE;
        end else begin
            unique case (state_q)
                sta_pkg::STA_LW_IDLE: begin
                    if (line_start) begin
                        state_q <= sta_pkg::STA_LW_COUNT;
                    end
                end
                sta_pkg::STA_LW_COUNT: begin
                    if (count_q == '0) begin
                        state_q <= sta_pkg::STA_LW_IDLE;
                    end
                end
            endcase
        end
    end

    // wait count loaded at line start, then counted down
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= '0;
        end else if (state_q == sta_pkg::STA_LW_IDLE && line_start) begin
            count_q <= wait_cnt;
        end else if (state_q == sta_pkg::STA_LW_COUNT && count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign waiting = (state_q == sta_pkg::STA_LW_COUNT);
    assign line_go = waiting && (count_q == '0);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            elapsed_q <= '0;
            loaded_q  <= '0;
        end else if (state_q == sta_pkg::STA_LW_IDLE && line_start) begin
            elapsed_q <= '0;
            loaded_q  <= wait_cnt;
        end else if (waiting) begin
            elapsed_q <= elapsed_q + 1'b1;
        end
    end

    a_go_after_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        line_go |-> elapsed_q == loaded_q)
        else $error("line released before or after the programmed wait");

    a_start_counts: assert property (@(posedge hclk) disable iff (!hresetn)
        (!waiting && line_start) |=> waiting)
        else $error("line start did not begin the wait");

endmodule

// ---- design/sta_pkg.sv ----
// types shared by the stream timing attribute bank
// assumes nothing beyond the register header
package sta_pkg;

    typedef enum logic [3:0] {
        STA_IDX_NONE,
        STA_IDX_WAIT,
        STA_IDX_HTOT,
        STA_IDX_VTOT,
        STA_IDX_POL,
        STA_IDX_HSW,
        STA_IDX_VSW,
        STA_IDX_HACT,
        STA_IDX_VACT,
        STA_IDX_HST,
        STA_IDX_VST,
        STA_IDX_TU,
        STA_IDX_STAT
    } sta_reg_e;

    typedef enum logic {
        STA_LW_IDLE,
        STA_LW_COUNT
    } sta_lw_state_e;

endpackage

// ---- design/sta_regs.svh ----
// register map and field constants of the stream timing attribute bank
// assumes byte addresses on a 32-bit AHB-Lite bus, one register per word
`ifndef STA_REGS_SVH
`define STA_REGS_SVH

// ----------------------------------------------------------------
// offsets (byte addresses, low 12 bits decoded)
// ----------------------------------------------------------------
`define STA_OFF_W           12
`define STA_OFF_LINE_WAIT   12'h59c
`define STA_OFF_HTOTAL      12'h5a0
`define STA_OFF_VTOTAL      12'h5a4
`define STA_OFF_POLARITY    12'h5a8
`define STA_OFF_HSWIDTH     12'h5ac
`define STA_OFF_VSWIDTH     12'h5b0
`define STA_OFF_HACTIVE     12'h5b4
`define STA_OFF_VACTIVE     12'h5b8
`define STA_OFF_HSTART      12'h5bc
`define STA_OFF_VSTART      12'h5c0
`define STA_OFF_TU_LEN      12'h5d0
`define STA_OFF_STATUS      12'h5d8

// ----------------------------------------------------------------
// field widths, positions and reset values
// ----------------------------------------------------------------
`define STA_W_WAIT          8
`define STA_W_TOTAL         16
`define STA_W_SWIDTH        15
`define STA_W_TU            7
`define STA_POL_HS          0
`define STA_POL_VS          1
`define STA_STAT_WAITING    0
`define STA_TU_RESET        7'h40
`define STA_TU_LSB          1
`define STA_HTRANS_ACTIVE   1

`endif

// ---- design/sta_top.sv ----
// stream timing attribute register bank with line-start wait timer
// assumes a single AHB-Lite master, word transfers only, one clock
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "sta_regs.svh"

module sta_top #(
    parameter int WAIT_W   = `STA_W_WAIT,
    parameter int TOTAL_W  = `STA_W_TOTAL,
    parameter int SWIDTH_W = `STA_W_SWIDTH
) (
    // clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // framing logic
    input  wire logic                line_start,
    output logic                     line_go,
    output logic                     line_waiting,
    // timing attributes
    output logic [TOTAL_W-1:0]       horiz_total,
    output logic [TOTAL_W-1:0]       vert_total,
    output logic                     vsync_polarity,
    output logic                     hsync_polarity,
    output logic [SWIDTH_W-1:0]      horiz_sync_width,
    output logic [SWIDTH_W-1:0]      vert_sync_width,
    output logic [TOTAL_W-1:0]       horiz_active,
    output logic [TOTAL_W-1:0]       vert_active,
    output logic [TOTAL_W-1:0]       horiz_start,
    output logic [TOTAL_W-1:0]       vert_start,
    output logic [`STA_W_TU-1:0]     transfer_unit_len
);

    logic [`STA_OFF_W-1:0] reg_addr;
    logic                  wr_en;
    logic                  rd_en;
    logic [31:0]           rd_data;
    sta_pkg::sta_reg_e     idx;

    logic [WAIT_W-1:0]     line_wait_q;
    logic [TOTAL_W-1:0]    htot_q;
    logic [TOTAL_W-1:0]    vtot_q;
    logic [1:0]            pol_q;
    logic [SWIDTH_W-1:0]   hsw_q;
    logic [SWIDTH_W-1:0]   vsw_q;
    logic [TOTAL_W-1:0]    hact_q;
    logic [TOTAL_W-1:0]    vact_q;
    logic [TOTAL_W-1:0]    hst_q;
    logic [TOTAL_W-1:0]    vst_q;
    logic [`STA_W_TU-1:0]  tu_q;
    logic                  tu_written_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic sta_pkg::sta_reg_e decode(input logic [`STA_OFF_W-1:0] a);
        case (a)
            `STA_OFF_LINE_WAIT: decode = sta_pkg::STA_IDX_WAIT;
            `STA_OFF_HTOTAL:    decode = sta_pkg::STA_IDX_HTOT;
            `STA_OFF_VTOTAL:    decode = sta_pkg::STA_IDX_VTOT;
            `STA_OFF_POLARITY:  decode = sta_pkg::STA_IDX_POL;
            `STA_OFF_HSWIDTH:   decode = sta_pkg::STA_IDX_HSW;
            `STA_OFF_VSWIDTH:   decode = sta_pkg::STA_IDX_VSW;
            `STA_OFF_HACTIVE:   decode = sta_pkg::STA_IDX_HACT;
            `STA_OFF_VACTIVE:   decode = sta_pkg::STA_IDX_VACT;
            `STA_OFF_HSTART:    decode = sta_pkg::STA_IDX_HST;
            `STA_OFF_VSTART:    decode = sta_pkg::STA_IDX_VST;
            `STA_OFF_TU_LEN:    decode = sta_pkg::STA_IDX_TU;
            `STA_OFF_STATUS:    decode = sta_pkg::STA_IDX_STAT;
            default:            decode = sta_pkg::STA_IDX_NONE;
        endcase
    endfunction

    assign idx = decode(reg_addr);

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    sta_ahb_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .reg_addr  (reg_addr),
        .wr_en     (wr_en),
        .rd_en     (rd_en),
        .rd_data   (rd_data)
    );

    // ------------------------------------------------------------
    // line-start wait
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_wait_q <= '0;
        end else if (wr_en && idx == sta_pkg::STA_IDX_WAIT) begin
            line_wait_q <= hwdata[WAIT_W-1:0];
        end
    end

    sta_line_wait #(
        .WAIT_W (WAIT_W)
    ) u_line_wait (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .line_start (line_start),
        .wait_cnt   (line_wait_q),
        .line_go    (line_go),
        .waiting    (line_waiting)
    );

    // ------------------------------------------------------------
    // totals and polarity
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            htot_q <= '0;
            vtot_q <= '0;
            pol_q  <= '0;
        end else if (wr_en) begin
            if (idx == sta_pkg::STA_IDX_HTOT) begin
                htot_q <= hwdata[TOTAL_W-1:0];
            end
            if (idx == sta_pkg::STA_IDX_VTOT) begin
                vtot_q <= hwdata[TOTAL_W-1:0];
            end
            if (idx == sta_pkg::STA_IDX_POL) begin
                pol_q <= hwdata[`STA_POL_VS:`STA_POL_HS];
            end
        end
    end

    // ------------------------------------------------------------
    // sync widths
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hsw_q <= '0;
            vsw_q <= '0;
        end else if (wr_en) begin
            if (idx == sta_pkg::STA_IDX_HSW) begin
                hsw_q <= hwdata[SWIDTH_W-1:0];
            end
            if (idx == sta_pkg::STA_IDX_VSW) begin
                vsw_q <= hwdata[SWIDTH_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // active size and start offsets
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hact_q <= '0;
            vact_q <= '0;
            hst_q  <= '0;
            vst_q  <= '0;
        end else if (wr_en) begin
            if (idx == sta_pkg::STA_IDX_HACT) begin
                hact_q <= hwdata[TOTAL_W-1:0];
            end
            if (idx == sta_pkg::STA_IDX_VACT) begin
                vact_q <= hwdata[TOTAL_W-1:0];
            end
            if (idx == sta_pkg::STA_IDX_HST) begin
                hst_q <= hwdata[TOTAL_W-1:0];
            end
            if (idx == sta_pkg::STA_IDX_VST) begin
                vst_q <= hwdata[TOTAL_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // transfer unit length, always even
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tu_q         <= `STA_TU_RESET;
            tu_written_q <= 1'b0;
        end else if (wr_en && idx == sta_pkg::STA_IDX_TU) begin
            tu_q         <= {hwdata[`STA_W_TU-1:`STA_TU_LSB], 1'b0};
            tu_written_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read mux, unused bits zero
    // ------------------------------------------------------------
    always_comb begin
        rd_data = '0;
        unique case (idx)
            sta_pkg::STA_IDX_WAIT: rd_data[WAIT_W-1:0]   = line_wait_q;
            sta_pkg::STA_IDX_HTOT: rd_data[TOTAL_W-1:0]  = htot_q;
            sta_pkg::STA_IDX_VTOT: rd_data[TOTAL_W-1:0]  = vtot_q;
            sta_pkg::STA_IDX_POL:  rd_data[`STA_POL_VS:`STA_POL_HS] = pol_q;
            sta_pkg::STA_IDX_HSW:  rd_data[SWIDTH_W-1:0] = hsw_q;
            sta_pkg::STA_IDX_VSW:  rd_data[SWIDTH_W-1:0] = vsw_q;
            sta_pkg::STA_IDX_HACT: rd_data[TOTAL_W-1:0]  = hact_q;
            sta_pkg::STA_IDX_VACT: rd_data[TOTAL_W-1:0]  = vact_q;
            sta_pkg::STA_IDX_HST:  rd_data[TOTAL_W-1:0]  = hst_q;
            sta_pkg::STA_IDX_VST:  rd_data[TOTAL_W-1:0]  = vst_q;
            sta_pkg::STA_IDX_TU:   rd_data[`STA_W_TU-1:0] = tu_q;
            sta_pkg::STA_IDX_STAT: rd_data[`STA_STAT_WAITING] = line_waiting;
            sta_pkg::STA_IDX_NONE: rd_data = '0;
        endcase
    end

    // ------------------------------------------------------------
    // attribute outputs
    // ------------------------------------------------------------
    assign horiz_total       = htot_q;
    assign vert_total        = vtot_q;
    assign vsync_polarity    = pol_q[`STA_POL_VS];
    assign hsync_polarity    = pol_q[`STA_POL_HS];
    assign horiz_sync_width  = hsw_q;
    assign vert_sync_width   = vsw_q;
    assign horiz_active      = hact_q;
    assign vert_active       = vact_q;
    assign horiz_start       = hst_q;
    assign vert_start        = vst_q;
    assign transfer_unit_len = tu_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_htot_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && idx == sta_pkg::STA_IDX_HTOT) |=> horiz_total == $past(hwdata[TOTAL_W-1:0]))
        else $error("horizontal total not taken from write");

    a_vtot_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && idx == sta_pkg::STA_IDX_VTOT) |=> vert_total == $past(hwdata[TOTAL_W-1:0]))
        else $error("vertical total not taken from write");

    a_pol_bits: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && idx == sta_pkg::STA_IDX_POL) |=>
            vsync_polarity == $past(hwdata[`STA_POL_VS]) && hsync_polarity == $past(hwdata[`STA_POL_HS]))
        else $error("sync polarity bits misplaced");

    a_hsw_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && idx == sta_pkg::STA_IDX_HSW) |=> horiz_sync_width == $past(hwdata[SWIDTH_W-1:0]))
        else $error("horizontal sync width not taken from write");

    a_vsw_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && idx == sta_pkg::STA_IDX_VSW) |=> vert_sync_width == $past(hwdata[SWIDTH_W-1:0]))
        else $error("vertical sync width not taken from write");

    a_active_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && idx == sta_pkg::STA_IDX_HACT) |=> horiz_active == $past(hwdata[TOTAL_W-1:0]))
        else $error("horizontal resolution not taken from write");

    a_vact_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !(wr_en && idx == sta_pkg::STA_IDX_VACT) |=> $stable(vert_active))
        else $error("vertical resolution changed without a write");

    a_hstart_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && idx == sta_pkg::STA_IDX_HST) |=> horiz_start == $past(hwdata[TOTAL_W-1:0]))
        else $error("horizontal start not taken from write");

    a_vstart_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && idx == sta_pkg::STA_IDX_VST) |=> vert_start == $past(hwdata[TOTAL_W-1:0]))
        else $error("vertical start not taken from write");

    a_tu_default: assert property (@(posedge hclk) disable iff (!hresetn)
        !tu_written_q |-> transfer_unit_len == `STA_TU_RESET)
        else $error("transfer unit length not at its reset value");

    a_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_en && idx == sta_pkg::STA_IDX_HTOT) |=> hreadyout && hrdata == {16'h0000, $past(horiz_total)})
        else $error("horizontal total read back wrong");

    a_wait_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && idx == sta_pkg::STA_IDX_WAIT) |=> line_wait_q == $past(hwdata[WAIT_W-1:0]))
        else $error("line-start wait not taken from write");

    a_wait_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_en && idx == sta_pkg::STA_IDX_WAIT) |=> hrdata == {24'h000000, $past(line_wait_q)})
        else $error("line-start wait read back wrong");

endmodule

// ---- dv/tb_sta_top.sv ----
// testbench for the stream timing attribute bank
// assumes sta_top as the only AHB-Lite slave, hready looped from hreadyout
`timescale 1ns/1ps
`include "sta_regs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb_sta_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, line_start = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, line_go, line_waiting, vsync_polarity, hsync_polarity;
    logic [31:0] hrdata;
    logic [15:0] horiz_total, vert_total, horiz_active, vert_active, horiz_start, vert_start;
    logic [14:0] horiz_sync_width, vert_sync_width;
    logic [6:0]  transfer_unit_len;
    int          miscompares = 0, n_checks = 0, cycles = 0, k;
    logic [11:0] offs [10] = '{`STA_OFF_LINE_WAIT, `STA_OFF_HTOTAL, `STA_OFF_VTOTAL, `STA_OFF_POLARITY,
        `STA_OFF_HSWIDTH, `STA_OFF_VSWIDTH, `STA_OFF_HACTIVE, `STA_OFF_VACTIVE, `STA_OFF_HSTART, `STA_OFF_VSTART};
    logic [31:0] msks [10] = '{32'hff, 32'hffff, 32'hffff, 32'h3, 32'h7fff, 32'h7fff,
        32'hffff, 32'hffff, 32'hffff, 32'hffff};
    logic [31:0] outs [10];
    localparam int min_bytes_per_transfer_unit = 10;
    int          waits [7] = '{0, 2, 5,
        8'h40,
        int'(`STA_TU_RESET) - min_bytes_per_transfer_unit,
        (int'(`STA_TU_RESET) - min_bytes_per_transfer_unit) / 2,
        (int'(`STA_TU_RESET) - min_bytes_per_transfer_unit) / 3};

    sta_top u_sta_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .line_start(line_start), .line_go(line_go),
        .line_waiting(line_waiting), .horiz_total(horiz_total), .vert_total(vert_total),
        .vsync_polarity(vsync_polarity), .hsync_polarity(hsync_polarity),
        .horiz_sync_width(horiz_sync_width), .vert_sync_width(vert_sync_width),
        .horiz_active(horiz_active), .vert_active(vert_active), .horiz_start(horiz_start),
        .vert_start(vert_start), .transfer_unit_len(transfer_unit_len));

    always #5 hclk = ~hclk;
    assign outs = '{32'(u_sta_top.line_wait_q), 32'(horiz_total), 32'(vert_total),
        32'({vsync_polarity, hsync_polarity}), 32'(horiz_sync_width), 32'(vert_sync_width),
        32'(horiz_active), 32'(vert_active), 32'(horiz_start), 32'(vert_start)};

    // ----------------------------------------------------------------
    // bus tasks and closing
    // ----------------------------------------------------------------
    task automatic ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= wr; hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        `CHK("tu_len_rst", 7'h40, transfer_unit_len)
        ahb_xfer(1'b0, `STA_OFF_TU_LEN, 32'h0);
        `CHK("tu_len_rd", 32'h40, rd)
        ahb_xfer(1'b1, `STA_OFF_TU_LEN, 32'hffffffff);
        ahb_xfer(1'b0, `STA_OFF_TU_LEN, 32'h0);
        `CHK("tu_len_wr", 32'h7e, rd)
        `CHK("tu_len_port", 7'h7e, transfer_unit_len)
        for (int i = 0; i < 10; i++) begin
            ahb_xfer(1'b1, offs[i], 32'hffffffff);
            ahb_xfer(1'b0, offs[i], 32'h0);
            `CHK("reg_ones", msks[i], rd)
            ahb_xfer(1'b1, offs[i], 32'h5a5a_a5a5 ^ i);
            ahb_xfer(1'b0, offs[i], 32'h0);
            `CHK("reg_pat", (32'h5a5a_a5a5 ^ i) & msks[i], rd)
            `CHK("reg_port", (32'h5a5a_a5a5 ^ i) & msks[i], outs[i])
        end
        ahb_xfer(1'b1, `STA_OFF_POLARITY, 32'h2);
        @(posedge hclk);
        `CHK("vs_pol", 1'b1, vsync_polarity)
        `CHK("hs_pol", 1'b0, hsync_polarity)
        ahb_xfer(1'b0, 12'h5c4, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        foreach (waits[j]) begin
            ahb_xfer(1'b1, `STA_OFF_LINE_WAIT, 32'(waits[j]));
            @(posedge hclk);
            line_start <= 1'b1;
            k = 0;
            do begin
                @(posedge hclk);
                line_start <= 1'b0;
                k++;
                if (k == 2) `CHK("waiting", 1'b1, line_waiting)
            end while (line_go !== 1'b1 && k < 300);
            `CHK("go_delay", waits[j] + 2, k)
            @(posedge hclk);
            `CHK("go_pulse", 1'b0, line_go)
        end
        ahb_xfer(1'b0, `STA_OFF_STATUS, 32'h0);
        `CHK("status_idle", 32'h0, rd)
        give_verdict();
    end
endmodule
